// *** verilog/boot_decode_consts.vh ***
// constants for boot strap decode and memory select decode
`ifndef BOOT_DECODE_CONSTS_VH
`define BOOT_DECODE_CONSTS_VH
// boot source codes
`define SRC_INTERNAL 3'h0
`define SRC_EXTERNAL 3'h1
`define SRC_WAIT 3'h2
`define SRC_NOR 3'h3
`define SRC_NAND 3'h4
`define SRC_UNDEF 3'h5
// low strap pair codes
`define LOW_INTERNAL 2'h0
`define LOW_EXTERNAL 2'h2
`define LOW_WAIT 2'h3
// strap patterns: full five-bit NOR and default, nand low three bits
`define PAT_NOR 5'h02
`define PAT_NAND_LOW 3'h6
`define PAT_DEFAULT 5'h02
// nand address cycles base and the value when not nand
`define NAND_CYCLES_BASE 3'h3
`define CYCLES_NONE 3'h0
// strap field positions
`define STRAP_CYCLES 4:3
`define STRAP_LOW3 2:0
`define STRAP_LOW2 1:0
// address windows: inclusive bounds
`define DRAM0_LO 32'h8000_0000
`define DRAM0_HI 32'h8FFF_FFFF
`define DRAM1_LO 32'h9000_0000
`define DRAM1_HI 32'h9FFF_FFFF
`define STATIC0_LO 32'hA000_0000
`define STATIC0_HI 32'hA7FF_FFFF
`define STATIC1_LO 32'hA800_0000
`define STATIC1_HI 32'hAFFF_FFFF
`define NAND_LO 32'hBB00_0000
`define NAND_HI 32'hBB00_11FF
// output levels
`define SEL_OFF 1'b0
`define PATH_32_ON 1'b1
`endif

// *** verilog/strap_sync.v ***
// two-stage synchroniser for a strap or pin group
`timescale 1ns/1ps
module strap_sync #(
  parameter WIDTH = 5
) (
  input wire mclk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_1;

  // first stage is read only by the second
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      stage_1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage_1 <= async_in;
      sync_out <= stage_1;
    end
  end
endmodule // strap_sync

// *** verilog/boot_select_and_memory_decode.v ***
// boot strap capture, boot source decode and memory select decode
//
// Contract
// - capture five boot straps during reset
// - low pair: internal, external, or wait
// - 00010 NOR; xx110 NAND, 3 to 6 cycles
// - 0x8xxxxxxx drives dram select 0 once dram_configured is high
// - 0xA0000000 region drives static select 0
// - only NOR and NAND windows bootable
// - unused dram select 1 reused as static 3
// - dram path two 16-bit parts, 32 bit
// - flash write-protect low blocks program/erase
// - eeprom writes only with strap closed
// - 32 KByte eeprom on first i2c port
`timescale 1ns/1ps
`include "boot_decode_consts.vh"
module boot_select_and_memory_decode (
  input wire mclk,
  input wire reset_n,
  input wire [4:0] boot_strap,
  input wire flash_protect_n,
  input wire eeprom_strap_closed,
  input wire [31:0] cpu_addr,
  input wire cpu_valid,
  input wire cpu_write,
  input wire dram_configured,
  output reg [2:0] boot_source,
  output reg [2:0] nand_addr_cycles,
  output reg [4:0] boot_pattern,
  output reg dram_select_0,
  output reg static_select_0,
  output reg static_select_3,
  output reg nand_enable_3,
  output reg nand_window,
  output reg boot_region,
  output reg unmapped,
  output reg flash_write_ok,
  output reg eeprom_write_ok,
  output reg dram_width_32
);
  wire [4:0] strap_s;
  wire flash_protect_s;
  wire eeprom_closed_s;
  reg [2:0] next_source;
  reg [2:0] next_cycles;
  reg hit_dram0;
  reg hit_dram1;
  reg hit_static0;
  reg hit_static1;
  reg hit_nand;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // strap flops keep tracking the pins while reset is low, so that
  // capture sees the real straps rather than a cleared synchroniser
  strap_sync #(.WIDTH(5)) u_strap_sync (
    .mclk(mclk),
    .reset_n(1'b1),
    .async_in(boot_strap),
    .sync_out(strap_s)
  );

  strap_sync #(.WIDTH(2)) u_prot_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({flash_protect_n, eeprom_strap_closed}),
    .sync_out({flash_protect_s, eeprom_closed_s})
  );

  // ----------------------------------------------------------------
  // boot decode
  // ----------------------------------------------------------------
  // strap pattern to boot source
  function [2:0] decode_source;
    input [4:0] pat;
    begin
      if (pat == `PAT_NOR)
        decode_source = `SRC_NOR;
      else if (pat[`STRAP_LOW3] == `PAT_NAND_LOW)
        decode_source = `SRC_NAND;
      else if (pat[`STRAP_LOW2] == `LOW_INTERNAL)
        decode_source = `SRC_INTERNAL;
      else if (pat[`STRAP_LOW2] == `LOW_EXTERNAL)
        decode_source = `SRC_EXTERNAL;
      else if (pat[`STRAP_LOW2] == `LOW_WAIT)
        decode_source = `SRC_WAIT;
      else
        decode_source = `SRC_UNDEF;
    end
  endfunction

  // nand address cycles: base count plus the two high straps
  function [2:0] nand_cycles;
    input [4:0] pat;
    begin
      // 3, 4, 5 or 6 cycles
      nand_cycles = `NAND_CYCLES_BASE + {1'b0, pat[`STRAP_CYCLES]};
    end
  endfunction

  // inclusive address window compare, shared by every select
  function window_hit;
    input [31:0] addr;
    input [31:0] lo;
    input [31:0] hi;
    begin
      window_hit = (addr >= lo) && (addr <= hi);
    end
  endfunction

  // source and nand cycle count from synchronised straps
  always @*
  begin
    next_source = decode_source(strap_s);
    if (next_source == `SRC_NAND)
      next_cycles = nand_cycles(strap_s);
    else
      next_cycles = `CYCLES_NONE;
  end

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // sample while reset is low
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      boot_pattern <= strap_s;
      boot_source <= next_source;
      nand_addr_cycles <= next_cycles;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // window hits from the live request
  always @*
  begin
    hit_dram0 = cpu_valid && window_hit(cpu_addr, `DRAM0_LO, `DRAM0_HI);
    // bank 1 window reused as static 3
    hit_dram1 = cpu_valid && window_hit(cpu_addr, `DRAM1_LO, `DRAM1_HI);
    hit_static0 = cpu_valid && window_hit(cpu_addr, `STATIC0_LO, `STATIC0_HI);
    // shared static select, also the third nand enable
    hit_static1 = cpu_valid && window_hit(cpu_addr, `STATIC1_LO, `STATIC1_HI);
    hit_nand = cpu_valid && window_hit(cpu_addr, `NAND_LO, `NAND_HI);
  end

  // ----------------------------------------------------------------
  // registered memory selects
  // ----------------------------------------------------------------
  // one select per window, one cycle after the request
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      dram_select_0 <= `SEL_OFF;
      static_select_0 <= `SEL_OFF;
      static_select_3 <= `SEL_OFF;
      nand_enable_3 <= `SEL_OFF;
      nand_window <= `SEL_OFF;
    end
    else
    begin
      dram_select_0 <= hit_dram0 && dram_configured;
      static_select_0 <= hit_static0;
      // second dram select as static 3
      static_select_3 <= hit_dram1;
      nand_enable_3 <= hit_static1;
      nand_window <= hit_nand;
    end
  end

  // ----------------------------------------------------------------
  // region classification
  // ----------------------------------------------------------------
  // bootable and unmapped flags follow the same request
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      boot_region <= `SEL_OFF;
      unmapped <= `SEL_OFF;
    end
    else
    begin
      boot_region <= hit_static0 || hit_nand;
      // valid request that no window claims
      unmapped <= cpu_valid && !(hit_dram0 || hit_dram1 || hit_static0 ||
                  hit_static1 || hit_nand);
    end
  end

  // ----------------------------------------------------------------
  // write protection and fixed path status
  // ----------------------------------------------------------------
  // protect levels come through the pin synchroniser, two cycles late
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      flash_write_ok <= `SEL_OFF;
      eeprom_write_ok <= `SEL_OFF;
      dram_width_32 <= `SEL_OFF;
    end
    else
    begin
      flash_write_ok <= hit_static0 && cpu_write && flash_protect_s;
      // eeprom sits on i2c port 1
      eeprom_write_ok <= eeprom_closed_s;
      dram_width_32 <= `PATH_32_ON;
    end
  end
endmodule // boot_select_and_memory_decode

// *** tb/board_straps.sv ***
// board strapping model feeding the boot straps
`timescale 1ns/1ps
module board_straps (
  input wire logic [4:0] ovr,
  input wire logic use_ovr,
  output wire logic [4:0] strap
);
  assign strap = use_ovr ? ovr : 5'h02;
endmodule  // board_straps

// *** tb/boot_decode_asserts.sv ***
// assertion checker for the boot and memory select decode
`timescale 1ns/1ps
module boot_decode_asserts (
  input wire mclk,
  input wire reset_n,
  input wire cpu_valid,
  input wire cpu_write,
  input wire dram_configured,
  input wire flash_protect_n,
  input wire [31:0] cpu_addr,
  input wire [2:0] boot_source,
  input wire [2:0] nand_addr_cycles,
  input wire [4:0] boot_pattern,
  input wire dram_select_0,
  input wire static_select_0,
  input wire static_select_3,
  input wire nand_enable_3,
  input wire nand_window,
  input wire boot_region,
  input wire flash_write_ok,
  input wire dram_width_32
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // address decode helpers
  wire [4:0] top = cpu_valid ? cpu_addr[31:27] : 5'h00;
  wire nand_hit = cpu_valid && cpu_addr >= 32'hBB00_0000 && cpu_addr <= 32'hBB00_11FF;
  a_dram_select: assert property ($past(reset_n) |-> dram_select_0 ==
    $past(top[4:1] == 4'h8 && dram_configured)) else $error("dram select wrong");
  a_static_zero: assert property ($past(reset_n) |->
    static_select_0 == $past(top == 5'h14)) else $error("static select 0 wrong");
  a_static_three: assert property ($past(reset_n) |->
    static_select_3 == $past(top[4:1] == 4'h9)) else $error("static select 3 wrong");
  a_nand_window: assert property ($past(reset_n) |->
    nand_window == $past(nand_hit) && (!nand_window || boot_region)) else $error("nand window");
  a_nor_boot: assert property (boot_pattern == 5'h02 |->
    boot_source == 3'h3) else $error("nor boot wrong");
  a_nand_cycles: assert property (boot_source == 3'h4 |->
    nand_addr_cycles == {1'b0, boot_pattern[4:3]} + 3'h3) else $error("nand cycles wrong");
  a_boot_hold: assert property ($past(reset_n) |-> $stable(boot_source) &&
    $stable(boot_pattern) && dram_width_32) else $error("boot config moved");
  a_flash_protect: assert property (!flash_protect_n [*5] |->
    !flash_write_ok) else $error("flash write while protected");
  a_nand_enable: assert property ($past(reset_n) |->
    nand_enable_3 == $past(top == 5'h15)) else $error("nand enable 3 wrong");
  a_boot_region: assert property ($past(reset_n) |->
    boot_region == $past(top == 5'h14 || nand_hit)) else $error("boot region wrong");
  a_flash_write: assert property (flash_write_ok |->
    $past(top == 5'h14 && cpu_write)) else $error("flash write outside nor");
  c_nor: cover property (boot_source == 3'h3);
  c_nand: cover property (boot_source == 3'h4);
  c_dram: cover property (dram_select_0);
  c_protect: cover property (!flash_protect_n && !flash_write_ok);
endmodule  // boot_decode_asserts
bind boot_select_and_memory_decode boot_decode_asserts chk (.*);

// *** tb/tb_boot_select_and_memory_decode.sv ***
// self-checking bench for the boot and memory select decode
`timescale 1ns/1ps
module tb_boot_select_and_memory_decode;
  logic mclk = 0, reset_n = 0, use_ovr = 0, flash_protect_n = 1, eeprom_strap_closed = 1;
  logic cpu_valid = 0, cpu_write = 0, dram_configured = 0;
  logic [4:0] ovr = 5'h00, boot_strap, boot_pattern;
  logic [31:0] cpu_addr = 32'h0000_0000;
  logic [2:0] boot_source, nand_addr_cycles;
  logic dram_select_0, static_select_0, static_select_3, nand_enable_3, nand_window;
  logic boot_region, unmapped, flash_write_ok, eeprom_write_ok, dram_width_32;
  int bad_count = 0, checks_done = 0;
  initial forever #20 mclk = ~mclk;
  board_straps board (.ovr(ovr), .use_ovr(use_ovr), .strap(boot_strap));
  boot_select_and_memory_decode dut (.*);
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // reset for four cycles with the given straps
  task automatic do_reset(logic [4:0] p, logic o);
    @(negedge mclk) {ovr, use_ovr, reset_n} = {p, o, 1'b0};
    repeat (4) @(negedge mclk);
    reset_n = 1;
    repeat (2) @(negedge mclk);
  endtask
  task automatic t_boot;
    logic [4:0] p [8] = '{5'h00, 5'h0a, 5'h03, 5'h02, 5'h06, 5'h0e, 5'h16, 5'h1e};
    logic [2:0] e [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};
    for (int i = 0; i < 8; i++)
    begin
      do_reset(p[i], 1);
      ovr = ~p[i];  // straps move after release
      repeat (4) @(negedge mclk);
      chk("source", boot_source, e[i]);
      chk("pattern", boot_pattern, p[i]);
      chk("cycles", nand_addr_cycles, i > 3 ? i - 1 : 0);
    end
    do_reset(5'h00, 0);
    chk("default", boot_source, 3'h3);
    chk("default pat", boot_pattern, 5'h02);
    $display("boot test done");
  endtask
  task automatic t_map;
    logic [31:0] a [8] = '{32'h8000_0000, 32'h8FFF_FFFF, 32'h9000_0000, 32'hA000_0000,
      32'hA800_0000, 32'hBB00_0000, 32'hBB00_11FF, 32'hBB00_1200};
    logic [6:0] e [8] = '{7'h40, 7'h40, 7'h20, 7'h12, 7'h08, 7'h06, 7'h06, 7'h01};
    // dram refused before setup, then setup done once and kept
    @(negedge mclk) {cpu_valid, cpu_addr} = {1'b1, 32'h8000_0000};
    @(negedge mclk) chk("refuse", dram_select_0, 0);
    dram_configured = 1;
    for (int i = 0; i < 8; i++)
    begin
      cpu_addr = a[i];
      @(negedge mclk) chk("sel", {dram_select_0, static_select_3, static_select_0, nand_enable_3,
        nand_window, boot_region, unmapped}, e[i]);
    end
    cpu_valid = 0;
    @(negedge mclk) chk("idle", {dram_select_0, static_select_0, boot_region, unmapped}, 0);
    {cpu_valid, cpu_write, cpu_addr} = {2'b11, 32'hA000_0000};
    @(negedge mclk) chk("wp", {flash_write_ok, eeprom_write_ok, dram_width_32}, 7);
    {flash_protect_n, eeprom_strap_closed} = 2'b00;
    repeat (5) @(negedge mclk);
    chk("wp on", {flash_write_ok, eeprom_write_ok}, 0);
    {flash_protect_n, eeprom_strap_closed, cpu_addr} = {2'b11, 32'h8000_0000};
    repeat (5) @(negedge mclk);
    chk("wp dram", {flash_write_ok, eeprom_write_ok}, 1);
    $display("map test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    #200000;
    bad_count++;
    close_out;
  end
  initial
  begin
    t_boot;
    t_map;
    close_out;
  end
endmodule  // tb_boot_select_and_memory_decode
